// [logic/stop_ctrl_pkg.sv]
// Purpose: constants and types for the stop-mode sequencer
// Assumes: device register offsets other than the clock control register are local choices
// Notes:   pclk is 20 MHz; counts other than NOP_CYCLES are derived from times below
package stop_ctrl_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 50;

  // device register map (reached through the device bus port)
  localparam logic [31:0] DEV_CLOCK_CTRL  = 32'h0000_0004;
  localparam logic [31:0] DEV_FLAG        = 32'h0000_0100;
  localparam logic [31:0] DEV_RESUME_A    = 32'h0000_0104;
  localparam logic [31:0] DEV_RESUME_B    = 32'h0000_0108;
  localparam logic [31:0] DEV_CLK_CTRL_0  = 32'h0000_010c;
  localparam logic [31:0] DEV_CLK_CTRL_2  = 32'h0000_0110;
  localparam logic [31:0] DEV_CLK_CTRL_3  = 32'h0000_0114;
  localparam logic [31:0] DEV_PROTECT     = 32'h0000_0118;
  localparam logic [31:0] DEV_MODE_2      = 32'h0000_011c;
  localparam logic [31:0] DEV_STOP_CMD    = 32'h0000_0120;
  localparam logic [31:0] DEV_ICR_BASE    = 32'h0000_0200;

  // device field positions
  localparam int unsigned FLAG_I_BIT        = 6;
  localparam int unsigned FLAG_IPL_LSB      = 12;
  localparam int unsigned BASE_CLK_SEL_BIT  = 7;  // 80h: low-speed base clock
  localparam int unsigned LOW_SRC_BIT       = 0;  // 0: main/256, 1: on-chip/4
  localparam int unsigned MAIN_OSC_STOP_BIT = 5;
  localparam int unsigned OSD_ENABLE_BIT    = 0;
  localparam int unsigned ONCHIP_EN_BIT     = 1;
  localparam int unsigned PROTECT_MODE_BIT  = 1;
  localparam int unsigned CLK_LOCK_BIT      = 1;
  localparam int unsigned STOP_GO_BIT       = 0;

  // interrupt levels
  localparam logic [2:0] LEVEL_MAX      = 3'h7;
  localparam logic [2:0] LEVEL_OFF      = 3'h0;
  localparam logic [6:0] FIRST_SOURCE   = 7'h01;
  localparam logic [6:0] LAST_SOURCE    = 7'h7f;

  // own register map (apb slave)
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_CFG    = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // commands written to REG_CMD[2:0]
  localparam logic [2:0] CMD_INIT  = 3'h1;
  localparam logic [2:0] CMD_STOP  = 3'h2;
  localparam logic [2:0] CMD_LOCK  = 3'h3;
  localparam logic [2:0] CMD_RESET = 3'h4;
  localparam logic [2:0] CMD_NMI   = 3'h5;

  // timing
  localparam int unsigned NOP_CYCLES     = 2;
  localparam int unsigned RESET_HOLD_US  = 10000;
  localparam int unsigned OSC_SETTLE_US  = 1000;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned OSC_SETTLE_CYC = OSC_SETTLE_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    ST_IDLE      = 5'h00, ST_FLAG_OFF  = 5'h01, ST_LVL_RD   = 5'h03, ST_LVL_WR    = 5'h02,
    ST_DUMMY_RD  = 5'h06, ST_IPL_ZERO  = 5'h07, ST_I_ON     = 5'h05, ST_NOP_WAIT  = 5'h04,
    ST_I_OFF     = 5'h0c, ST_WAKE_LVL  = 5'h0d, ST_IPL_SET  = 5'h0f, ST_RES_A     = 5'h0e,
    ST_RES_B     = 5'h0a, ST_OSD_OFF   = 5'h0b, ST_OSC_ON   = 5'h09, ST_OSC_WAIT  = 5'h08,
    ST_CLK_SEL   = 5'h18, ST_I_SET     = 5'h19, ST_STOP     = 5'h1b, ST_ASLEEP    = 5'h1a,
    ST_WAKE_WAIT = 5'h1e, ST_RESUME_A  = 5'h1f, ST_RESUME_B = 5'h1d, ST_INIT_A    = 5'h1c,
    ST_INIT_B    = 5'h14, ST_LOCK_CM0  = 5'h15, ST_LOCK_CCR = 5'h17, ST_LOCK_PON  = 5'h16,
    ST_LOCK_PM2  = 5'h12, ST_LOCK_POFF = 5'h13, ST_RST_HOLD = 5'h11
  } state_t;

  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic       periph_wake_off;
    logic       osd_used;
    logic       clk_onchip;
    logic [2:0] processor_priority_level;
    logic [2:0] wake_lvl;
    logic [6:0] wake_src;
  } cfg_t;

endpackage : stop_ctrl_pkg

// [logic/dev_bus_master.sv]
// Purpose: one apb transfer toward the device registers per request
// Assumes: request held stable by the caller until done
// Notes:   done is combinational, high in the completing access cycle
`timescale 1ns/100ps
module dev_bus_master (
  input  wire logic                   pclk,        // clock
  input  wire logic                   presetn,     // async reset, low
  input  wire logic                   req_valid,   // request pending
  input  wire stop_ctrl_pkg::bus_req_t req,        // request contents
  output logic                        done,        // transfer completes
  output logic [31:0]                 rdata,       // read data at done
  output logic                        m_psel,      // apb select
  output logic                        m_penable,   // apb enable
  output logic                        m_pwrite,    // apb direction
  output logic [31:0]                 m_paddr,     // apb address
  output logic [31:0]                 m_pwdata,    // apb write data
  input  wire logic [31:0]            m_prdata,    // apb read data
  input  wire logic                   m_pready     // apb ready
);

  assign done  = m_psel & m_penable & m_pready;
  assign rdata = m_prdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_psel    <= 1'b0;
      m_penable <= 1'b0;
      m_pwrite  <= 1'b0;
      m_paddr   <= 32'h0000_0000;
      m_pwdata  <= 32'h0000_0000;
    end else if (done) begin
      m_psel    <= 1'b0;
      m_penable <= 1'b0;
    end else if (m_psel) begin
      m_penable <= 1'b1;
    end else if (req_valid) begin
      m_psel   <= 1'b1;
      m_pwrite <= req.write;
      m_paddr  <= req.addr;
      m_pwdata <= req.wdata;
    end
  end

endmodule : dev_bus_master

// [logic/stop_seq_ctrl.sv]
// Purpose: host sequencer that prepares, stops, wakes and locks the clock generator
// Assumes: device registers reached over an apb master port; software uses an apb slave
// Notes:   one command at a time; reset command aborts anything
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module stop_seq_ctrl #(
  parameter int unsigned RESET_HOLD_CYCLES = stop_ctrl_pkg::RESET_HOLD_CYC,
  parameter int unsigned OSC_SETTLE_CYCLES = stop_ctrl_pkg::OSC_SETTLE_CYC
) (
  input  wire logic        pclk,        // clock, 20 MHz
  input  wire logic        presetn,     // async reset, low
  input  wire logic        psel,        // apb slave select
  input  wire logic        penable,     // apb slave enable
  input  wire logic        pwrite,      // apb slave direction
  input  wire logic [7:0]  paddr,       // apb slave address
  input  wire logic [31:0] pwdata,      // apb slave write data
  output logic [31:0]      prdata,      // apb slave read data
  output logic             pready,      // apb slave ready
  output logic             pslverr,     // apb slave error
  output logic             m_psel,      // device bus select
  output logic             m_penable,   // device bus enable
  output logic             m_pwrite,    // device bus direction
  output logic [31:0]      m_paddr,     // device bus address
  output logic [31:0]      m_pwdata,    // device bus write data
  input  wire logic [31:0] m_prdata,    // device bus read data
  input  wire logic        m_pready,    // device bus ready
  input  wire logic        dev_awake,   // device running, pin
  output logic             dev_reset_n, // device reset pin, low
  output logic             dev_nmi      // device nmi request
);

  stop_ctrl_pkg::state_t   state;
  stop_ctrl_pkg::state_t   next_state;
  stop_ctrl_pkg::cfg_t     cfg;
  stop_ctrl_pkg::bus_req_t req;
  logic                    req_valid;
  logic                    done;
  logic [31:0]             bus_rdata;
  logic [31:0]             last_rdata;
  logic [23:0]             cnt;
  logic [23:0]             next_cnt;
  logic                    refused;
  logic                    awake_meta;
  logic                    awake_s;

  // software side decode
  wire       setup    = psel & ~penable;
  wire       wr_en    = psel & penable & pwrite & pready;
  wire       hit_cmd  = (paddr == stop_ctrl_pkg::REG_CMD);
  wire       hit_cfg  = (paddr == stop_ctrl_pkg::REG_CFG);
  wire       hit_stat = (paddr == stop_ctrl_pkg::REG_STATUS);
  wire       hit_rd   = (paddr == stop_ctrl_pkg::REG_RDATA);
  wire       hit_any  = hit_cmd | hit_cfg | hit_stat | hit_rd;
  wire       cmd_wr   = wr_en & hit_cmd;
  wire [2:0] cmd      = pwdata[2:0];
  wire       idle     = (state == stop_ctrl_pkg::ST_IDLE);
  wire       asleep   = (state == stop_ctrl_pkg::ST_ASLEEP) |
                        (state == stop_ctrl_pkg::ST_WAKE_WAIT);
  wire       go_init  = cmd_wr & idle & (cmd == stop_ctrl_pkg::CMD_INIT);
  wire       go_stop  = cmd_wr & idle & (cmd == stop_ctrl_pkg::CMD_STOP);
  wire       go_lock  = cmd_wr & idle & (cmd == stop_ctrl_pkg::CMD_LOCK);
  wire       go_reset = cmd_wr & (cmd == stop_ctrl_pkg::CMD_RESET);
  wire       go_nmi   = cmd_wr & (state == stop_ctrl_pkg::ST_WAKE_WAIT) &
                        (cmd == stop_ctrl_pkg::CMD_NMI);
  wire       accepted = go_init | go_stop | go_lock | go_reset | go_nmi;
  wire [31:0] status  = {19'h0_0000, 3'h0, state, 2'h0, refused, asleep, ~idle};
  wire [31:0] rd_mux  = hit_cmd  ? 32'h0000_0000 :
                        hit_cfg  ? {16'h0000, cfg} :
                        hit_stat ? status :
                        hit_rd   ? last_rdata : 32'h0000_0000;

  // device side words
  wire [31:0] icr_addr  = stop_ctrl_pkg::DEV_ICR_BASE + {23'h00_0000, cnt[6:0], 2'h0};
  wire [31:0] wake_addr = stop_ctrl_pkg::DEV_ICR_BASE + {23'h00_0000, cfg.wake_src, 2'h0};
  wire [31:0] i_word    = 32'h0000_0001 << stop_ctrl_pkg::FLAG_I_BIT;
  wire [31:0] ipl_word  = {29'h0000_0000, cfg.processor_priority_level} << stop_ctrl_pkg::FLAG_IPL_LSB;
  wire [31:0] low_clk   = (32'h0000_0001 << stop_ctrl_pkg::BASE_CLK_SEL_BIT) |
                          ({31'h0000_0000, cfg.clk_onchip} << stop_ctrl_pkg::LOW_SRC_BIT);
  wire [31:0] max_word  = {29'h0000_0000, stop_ctrl_pkg::LEVEL_MAX};
  wire [31:0] res_word  = {29'h0000_0000, cfg.processor_priority_level};
  wire        lvl_zero  = (bus_rdata[2:0] == stop_ctrl_pkg::LEVEL_OFF);
  wire        last_src  = (cnt[6:0] == stop_ctrl_pkg::LAST_SOURCE);

  // device request per state
  always_comb begin
    req_valid = 1'b1;
    req.write = 1'b1;
    req.addr  = stop_ctrl_pkg::DEV_FLAG;
    req.wdata = 32'h0000_0000;
    case (state)
      stop_ctrl_pkg::ST_INIT_A:    begin req.addr = stop_ctrl_pkg::DEV_RESUME_A;
                                         req.wdata = max_word; end
      stop_ctrl_pkg::ST_INIT_B:    begin req.addr = stop_ctrl_pkg::DEV_RESUME_B;
                                         req.wdata = max_word; end
      stop_ctrl_pkg::ST_FLAG_OFF:  req.wdata = 32'h0000_0000;
      stop_ctrl_pkg::ST_LVL_RD:    begin req.write = 1'b0; req.addr = icr_addr; end
      stop_ctrl_pkg::ST_LVL_WR:    req.addr = icr_addr;
      stop_ctrl_pkg::ST_DUMMY_RD:  begin req.write = 1'b0;
                                         req.addr = stop_ctrl_pkg::DEV_ICR_BASE; end
      stop_ctrl_pkg::ST_IPL_ZERO:  req.wdata = 32'h0000_0000;
      stop_ctrl_pkg::ST_I_ON:      req.wdata = i_word;
      stop_ctrl_pkg::ST_I_OFF:     req.wdata = 32'h0000_0000;
      stop_ctrl_pkg::ST_WAKE_LVL:  begin req.addr = wake_addr;
                                         req.wdata = {29'h0000_0000, cfg.wake_lvl}; end
      stop_ctrl_pkg::ST_IPL_SET:   req.wdata = ipl_word;
      stop_ctrl_pkg::ST_RES_A:     begin req.addr = stop_ctrl_pkg::DEV_RESUME_A;
                                         req.wdata = res_word; end
      stop_ctrl_pkg::ST_RES_B:     begin req.addr = stop_ctrl_pkg::DEV_RESUME_B;
                                         req.wdata = res_word; end
      stop_ctrl_pkg::ST_OSD_OFF:   req.addr = stop_ctrl_pkg::DEV_CLK_CTRL_2;
      stop_ctrl_pkg::ST_OSC_ON:    begin req.addr = stop_ctrl_pkg::DEV_CLK_CTRL_3;
                                         req.wdata = 32'h0000_0001 <<
                                                     stop_ctrl_pkg::ONCHIP_EN_BIT; end
      stop_ctrl_pkg::ST_CLK_SEL:   begin req.addr = stop_ctrl_pkg::DEV_CLOCK_CTRL;
                                         req.wdata = low_clk; end
      stop_ctrl_pkg::ST_I_SET:     req.wdata = i_word | ipl_word;
      stop_ctrl_pkg::ST_STOP:      begin req.addr = stop_ctrl_pkg::DEV_STOP_CMD;
                                         req.wdata = 32'h0000_0001 <<
                                                     stop_ctrl_pkg::STOP_GO_BIT; end
      stop_ctrl_pkg::ST_RESUME_A:  begin req.addr = stop_ctrl_pkg::DEV_RESUME_A;
                                         req.wdata = max_word; end
      stop_ctrl_pkg::ST_RESUME_B:  begin req.addr = stop_ctrl_pkg::DEV_RESUME_B;
                                         req.wdata = max_word; end
      stop_ctrl_pkg::ST_LOCK_CM0:  req.addr = stop_ctrl_pkg::DEV_CLK_CTRL_0;
      stop_ctrl_pkg::ST_LOCK_CCR:  req.addr = stop_ctrl_pkg::DEV_CLOCK_CTRL;
      stop_ctrl_pkg::ST_LOCK_PON:  begin req.addr = stop_ctrl_pkg::DEV_PROTECT;
                                         req.wdata = 32'h0000_0001 <<
                                                     stop_ctrl_pkg::PROTECT_MODE_BIT; end
      stop_ctrl_pkg::ST_LOCK_PM2:  begin req.addr = stop_ctrl_pkg::DEV_MODE_2;
                                         req.wdata = 32'h0000_0001 <<
                                                     stop_ctrl_pkg::CLK_LOCK_BIT; end
      stop_ctrl_pkg::ST_LOCK_POFF: req.addr = stop_ctrl_pkg::DEV_PROTECT;
      default:                     req_valid = 1'b0;
    endcase
  end

  // sequence
  always_comb begin
    next_state = state;
    case (state)
      stop_ctrl_pkg::ST_IDLE:
        if (go_init)      next_state = stop_ctrl_pkg::ST_INIT_A;
        else if (go_stop) next_state = stop_ctrl_pkg::ST_FLAG_OFF;
        else if (go_lock) next_state = stop_ctrl_pkg::ST_LOCK_CM0;
      stop_ctrl_pkg::ST_INIT_A:    if (done) next_state = stop_ctrl_pkg::ST_INIT_B;
      stop_ctrl_pkg::ST_INIT_B:    if (done) next_state = stop_ctrl_pkg::ST_IDLE;
      stop_ctrl_pkg::ST_FLAG_OFF:  if (done) next_state = stop_ctrl_pkg::ST_LVL_RD;
      stop_ctrl_pkg::ST_LVL_RD:
        if (done) begin
          if (!lvl_zero)     next_state = stop_ctrl_pkg::ST_LVL_WR;
          else if (last_src) next_state = stop_ctrl_pkg::ST_DUMMY_RD;
        end
      stop_ctrl_pkg::ST_LVL_WR:
        if (done) next_state = last_src ? stop_ctrl_pkg::ST_DUMMY_RD : stop_ctrl_pkg::ST_LVL_RD;
      stop_ctrl_pkg::ST_DUMMY_RD:  if (done) next_state = stop_ctrl_pkg::ST_IPL_ZERO;
      stop_ctrl_pkg::ST_IPL_ZERO:  if (done) next_state = stop_ctrl_pkg::ST_I_ON;
      stop_ctrl_pkg::ST_I_ON:      if (done) next_state = stop_ctrl_pkg::ST_NOP_WAIT;
      stop_ctrl_pkg::ST_NOP_WAIT:  if (cnt == 24'h00_0000) next_state = stop_ctrl_pkg::ST_I_OFF;
      stop_ctrl_pkg::ST_I_OFF:     // reset/nmi-only wake skips the wake level
        if (done) next_state = cfg.periph_wake_off ? stop_ctrl_pkg::ST_IPL_SET :
                                                     stop_ctrl_pkg::ST_WAKE_LVL;
      stop_ctrl_pkg::ST_WAKE_LVL:  if (done) next_state = stop_ctrl_pkg::ST_IPL_SET;
      stop_ctrl_pkg::ST_IPL_SET:   if (done) next_state = stop_ctrl_pkg::ST_RES_A;
      stop_ctrl_pkg::ST_RES_A:     if (done) next_state = stop_ctrl_pkg::ST_RES_B;
      stop_ctrl_pkg::ST_RES_B:
        if (done) next_state = cfg.osd_used   ? stop_ctrl_pkg::ST_OSD_OFF :
                               cfg.clk_onchip ? stop_ctrl_pkg::ST_OSC_ON :
                                                stop_ctrl_pkg::ST_OSC_WAIT;
      stop_ctrl_pkg::ST_OSD_OFF:
        if (done) next_state = cfg.clk_onchip ? stop_ctrl_pkg::ST_OSC_ON :
                                                stop_ctrl_pkg::ST_OSC_WAIT;
      stop_ctrl_pkg::ST_OSC_ON:    if (done) next_state = stop_ctrl_pkg::ST_CLK_SEL;
      stop_ctrl_pkg::ST_OSC_WAIT:
        if (cnt == 24'h00_0000) next_state = stop_ctrl_pkg::ST_CLK_SEL;
      stop_ctrl_pkg::ST_CLK_SEL:   if (done) next_state = stop_ctrl_pkg::ST_I_SET;
      stop_ctrl_pkg::ST_I_SET:     if (done) next_state = stop_ctrl_pkg::ST_STOP;
      stop_ctrl_pkg::ST_STOP:      if (done) next_state = stop_ctrl_pkg::ST_ASLEEP;
      stop_ctrl_pkg::ST_ASLEEP:    if (!awake_s) next_state = stop_ctrl_pkg::ST_WAKE_WAIT;
      stop_ctrl_pkg::ST_WAKE_WAIT:
        if (awake_s) next_state = stop_ctrl_pkg::ST_RESUME_A;
      stop_ctrl_pkg::ST_RESUME_A:  if (done) next_state = stop_ctrl_pkg::ST_RESUME_B;
      stop_ctrl_pkg::ST_RESUME_B:  if (done) next_state = stop_ctrl_pkg::ST_IDLE;
      stop_ctrl_pkg::ST_LOCK_CM0:  if (done) next_state = stop_ctrl_pkg::ST_LOCK_CCR;
      stop_ctrl_pkg::ST_LOCK_CCR:  if (done) next_state = stop_ctrl_pkg::ST_LOCK_PON;
      stop_ctrl_pkg::ST_LOCK_PON:  if (done) next_state = stop_ctrl_pkg::ST_LOCK_PM2;
      stop_ctrl_pkg::ST_LOCK_PM2:  if (done) next_state = stop_ctrl_pkg::ST_LOCK_POFF;
      stop_ctrl_pkg::ST_LOCK_POFF: if (done) next_state = stop_ctrl_pkg::ST_IDLE;
      stop_ctrl_pkg::ST_RST_HOLD:  if (cnt == 24'h00_0000) next_state = stop_ctrl_pkg::ST_IDLE;
      default:                     next_state = stop_ctrl_pkg::ST_IDLE;
    endcase
    if (go_reset) next_state = stop_ctrl_pkg::ST_RST_HOLD;
  end

  // shared counter: source index or wait length
  always_comb begin
    next_cnt = (cnt != 24'h00_0000) ? cnt - 24'h00_0001 : cnt;
    if (go_reset)
      next_cnt = 24'(RESET_HOLD_CYCLES - 1);
    else if (state == stop_ctrl_pkg::ST_FLAG_OFF)
      next_cnt = {17'h0_0000, stop_ctrl_pkg::FIRST_SOURCE};
    else if ((state == stop_ctrl_pkg::ST_LVL_RD) || (state == stop_ctrl_pkg::ST_LVL_WR))
      next_cnt = (done && next_state == stop_ctrl_pkg::ST_LVL_RD) ? cnt + 24'h00_0001 : cnt;
    else if (state == stop_ctrl_pkg::ST_I_ON)
      next_cnt = 24'(stop_ctrl_pkg::NOP_CYCLES - 1);
    else if (next_state == stop_ctrl_pkg::ST_OSC_WAIT && state != stop_ctrl_pkg::ST_OSC_WAIT)
      next_cnt = 24'(OSC_SETTLE_CYCLES - 1);
  end

  dev_bus_master u_master (
    .pclk      (pclk),
    .presetn   (presetn),
    .req_valid (req_valid),
    .req       (req),
    .done      (done),
    .rdata     (bus_rdata),
    .m_psel    (m_psel),
    .m_penable (m_penable),
    .m_pwrite  (m_pwrite),
    .m_paddr   (m_paddr),
    .m_pwdata  (m_pwdata),
    .m_prdata  (m_prdata),
    .m_pready  (m_pready)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= stop_ctrl_pkg::ST_IDLE;
      cnt        <= 24'h00_0000;
      awake_meta <= 1'b1;  // idle level of a running device
      awake_s    <= 1'b1;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      awake_meta <= dev_awake;
      awake_s    <= awake_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg        <= stop_ctrl_pkg::CFG_RESET;
      refused    <= 1'b0;
      last_rdata <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      if (wr_en && hit_cfg && idle) cfg <= stop_ctrl_pkg::cfg_t'(pwdata[15:0]);
      if (cmd_wr) refused <= ~accepted;
      if (done && !m_pwrite) last_rdata <= bus_rdata;
    end
  end

  // pin drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_reset_n <= 1'b1;
      dev_nmi     <= 1'b0;
    end else begin
      dev_reset_n <= (next_state != stop_ctrl_pkg::ST_RST_HOLD);
      if (go_nmi)
        dev_nmi <= 1'b1;
      else if (next_state != stop_ctrl_pkg::ST_WAKE_WAIT)
        dev_nmi <= 1'b0;
    end
  end

endmodule : stop_seq_ctrl

// [test/stop_seq_ctrl_monitor.sv]
// Purpose: port assertions for the stop sequencer
// Assumes: bench sets the reset hold to 8 cycles
// Notes:   bound below
`timescale 1ns/100ps
module stop_seq_ctrl_monitor (
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, // slave
  input wire logic [7:0]  paddr,                                   // address
  input wire logic [31:0] prdata, m_paddr,                         // data
  input wire logic        m_psel, m_penable, m_pready, dev_reset_n, dev_nmi // device
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_idle; !psel |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("ready without select");
  property p_err; pready && paddr > 8'h0c |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped not flagged");
  property p_cmd; pready && !pwrite && paddr == 8'h00 |-> prdata == 32'h0; endproperty
  a_cmd: assert property (p_cmd) else $error("command reads nonzero");
  property p_hold; m_psel && !m_penable |=> m_penable && $stable(m_paddr); endproperty
  a_hold: assert property (p_hold) else $error("device request moved");
  property p_gap; m_penable && m_pready |=> !m_psel; endproperty
  a_gap: assert property (p_gap) else $error("no idle after transfer");
  property p_rst; $fell(dev_reset_n) |-> !dev_reset_n [*8]; endproperty
  a_rst: assert property (p_rst) else $error("reset pin too short");
  property p_nmi; dev_nmi |-> !m_psel && dev_reset_n; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi outside wake wait");
endmodule : stop_seq_ctrl_monitor
bind stop_seq_ctrl stop_seq_ctrl_monitor i_mon (.*);

// [test/dev_model.sv]
// Purpose: behavioural device registers and stop behaviour
// Assumes: words indexed by address bits 9:2
// Notes:   addresses with bit 2 set answer one cycle late
`timescale 1ns/100ps
module dev_model (
  input wire logic        pclk, presetn, psel, penable, pwrite, nmi, reset_n, // pins
  input wire logic        irq,   // source 2 wake request, an eligible kind
  input wire logic [31:0] paddr, pwdata, // request
  output logic [31:0]     prdata,        // read data
  output logic            pready, awake  // answer, running
);
  logic [31:0] mem [256];
  logic        slow;
  wire prot = mem[71][1] && (paddr[9:2] == 8'h43 || paddr[9:2] == 8'h44);
  wire hit  = pready && pwrite && !prot;
  assign pready = psel && penable && !slow;
  assign prdata = pready ? mem[paddr[9:2]] : ~paddr; // no stale value when idle
  initial begin foreach (mem[i]) mem[i] = 32'h0; mem[129] = 32'h3; mem[68] = 32'h1; end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin slow <= 1'b0; awake <= 1'b1; end
    else begin
      slow <= psel && !penable && paddr[2];
      if (hit) mem[paddr[9:2]] <= pwdata;
      if (hit && paddr == 32'h120) awake <= 1'b0;
      else if (nmi || !reset_n) awake <= 1'b1;
      else if (irq && mem[130][2:0] > mem[65][2:0]) awake <= 1'b1;
    end
  end
endmodule : dev_model

// [test/tb_stop_seq_ctrl.sv]
// Purpose: register-level tests of the stop sequencer
// Assumes: short reset hold and settle counts
// Notes:   device registers inspected in the model
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb_stop_seq_ctrl;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq = 0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, m_paddr, m_pwdata, m_prdata, q;
  logic pready, pslverr, m_psel, m_penable, m_pwrite, m_pready, dev_awake, dev_reset_n, dev_nmi;
  int errors = 0, n_checks = 0;
  always #25 pclk = ~pclk;
  stop_seq_ctrl #(.RESET_HOLD_CYCLES(8), .OSC_SETTLE_CYCLES(4)) i_dut (.*);
  dev_model i_dev (.pclk, .presetn, .psel(m_psel), .penable(m_penable), .pwrite(m_pwrite),
    .nmi(dev_nmi), .reset_n(dev_reset_n), .irq(irq), .paddr(m_paddr), .pwdata(m_pwdata),
    .prdata(m_prdata), .pready(m_pready), .awake(dev_awake));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata; e = pslverr; psel <= 0; penable <= 0;
  endtask : xfer
  task automatic wait_st(input logic [31:0] m, v);
    repeat (3000) begin xfer(0, 8'h08, 0); if ((q & m) === v) return; end
    errors++;
    tally_and_finish;
  endtask : wait_st
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin #2000000; errors++; tally_and_finish; end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    xfer(0, 8'h08, 0); `CHK("status", 32'h0, q)
    xfer(0, 8'h04, 0); `CHK("cfg", 32'h0, q)
    xfer(0, 8'h40, 0); `CHK("slverr", 1'b1, e)
    xfer(0, 8'h00, 0); `CHK("cmd_rd", 32'h0, q)
    xfer(1, 8'h00, 1); wait_st(1, 0); `CHK("res_a", 32'h7, i_dev.mem[65])
    xfer(1, 8'h04, 32'h6e82); xfer(1, 8'h00, 2); wait_st(2, 2);
    `CHK("icr1", 32'h0, i_dev.mem[129])
    `CHK("icr2", 32'h5, i_dev.mem[130])
    `CHK("res_b", 32'h3, i_dev.mem[66])
    `CHK("osd", 32'h0, i_dev.mem[68])
    `CHK("ccr", 32'h81, i_dev.mem[1])
    `CHK("oco", 32'h2, i_dev.mem[69])
    `CHK("flag", 32'h3040, i_dev.mem[64])
    xfer(1, 8'h00, 1); xfer(0, 8'h08, 0); `CHK("refused", 1'b1, q[2])
    irq <= 1; wait_st(1, 0); irq <= 0;
    `CHK("res_a", 32'h7, i_dev.mem[65])
    `CHK("res_b", 32'h7, i_dev.mem[66])
    xfer(1, 8'h04, 32'h8b02); xfer(1, 8'h00, 2); wait_st(2, 2);
    `CHK("icr2_off", 32'h0, i_dev.mem[130])
    `CHK("ccr_main", 32'h80, i_dev.mem[1])
    `CHK("flag_ipl2", 32'h2040, i_dev.mem[64])
    irq <= 1; repeat (6) @(posedge pclk); irq <= 0;
    xfer(0, 8'h08, 0); `CHK("no_wake", 1'b1, q[1])
    xfer(1, 8'h00, 5); wait_st(1, 0); `CHK("res_a", 32'h7, i_dev.mem[65])
    xfer(1, 8'h00, 3); wait_st(1, 0); `CHK("pm2", 32'h2, i_dev.mem[71])
    `CHK("protect_register", 32'h0, i_dev.mem[70])
    `CHK("ccr", 32'h0, i_dev.mem[1])
    xfer(1, 8'h00, 4); @(posedge pclk); `CHK("rst_low", 1'b0, dev_reset_n)
    wait_st(1, 0); `CHK("rst_pin", 1'b1, dev_reset_n)
    tally_and_finish;
  end
endmodule : tb_stop_seq_ctrl
